/* File: gis_bus_model.sv */
// Behavioural far-side model that drives bus states and second-register events.
module gis_bus_model
	import gis_pkg::*;
(
	input  wire logic  clk,
	output gis_bus_type bus,
	output logic [6:0]  second_cond
);
	timeunit 1ns;
	timeprecision 1ns;
	gis_bus_type base;
	initial begin
		base = '0;
		bus = '0;
		second_cond = '0;
	end
	task automatic set_base(input gis_bus_type v);
		@(posedge clk);
		base = v;
		bus <= v;
	endtask : set_base
	// Event terms count once per high cycle, so every event is a single-cycle pulse.
	task automatic pulse(input gis_bus_type v);
		@(posedge clk);
		bus <= base | v;
		@(posedge clk);
		bus <= base;
	endtask : pulse
	task automatic cond(input logic [6:0] m);
		@(posedge clk);
		second_cond <= m;
		@(posedge clk);
		second_cond <= '0;
	endtask : cond
endmodule : gis_bus_model

/* File: gis_flag_reg.sv */
// Sticky clear-on-read status flags with deferred setting during a read.
module gis_flag_reg
	import gis_pkg::*;
#(
	parameter int W = 8
) (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic [W-1:0] set_ev,
	input  wire logic         rd_clear,
	input  wire logic         sw_clear,
	output logic      [W-1:0] flags
);

	typedef struct packed {
		logic [W-1:0] flags;
		logic [W-1:0] pending;
	} gis_flag_type;

	gis_flag_type state;
	gis_flag_type next_state;

	if (W < 1 || W > 32) begin : g_bad_w
		$error("gis_flag_reg width out of range");
	end

	// An event seen in the read cycle is parked and lands one cycle later,
	// so the clear caused by that read cannot swallow it.
	always_comb begin
		next_state = state;
		if (sw_clear) begin
			// An event in the reset cycle is parked rather than dropped.
			next_state.flags   = '0;
			next_state.pending = set_ev;
		end else if (rd_clear) begin
			next_state.flags   = state.pending;
			next_state.pending = set_ev;
		end else begin
			next_state.flags   = state.flags | state.pending | set_ev;
			next_state.pending = '0;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign flags = state.flags;

endmodule : gis_flag_reg

/* File: gis_interrupt_status.sv */
// Top of the bus interrupt status and mask logic with its AXI4-Lite slave.
module gis_interrupt_status
	import gis_pkg::*;
#(
	parameter int AW = ADDR_W
) (
	input  wire logic              clk,
	input  wire logic              rst,
	input  wire logic [AW-1:0]     s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [DATA_W-1:0] s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [AW-1:0]     s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [DATA_W-1:0]      s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	input  wire gis_bus_type       bus,
	input  wire logic [6:0]        second_cond,
	output logic                   irq,
	output logic                   dac_holdoff
);

	gis_top_type state;
	gis_top_type next_state;

	logic [3:0]  first_set;
	logic [7:0]  second_set;
	logic [3:0]  first_flags;
	logic [7:0]  second_flags;
	logic        wr_fire;
	logic        rd_fire;
	logic        rd_clear0;
	logic        rd_clear1;
	logic        sw_reset;
	logic        sum0;
	logic        sum1;
	logic        poll_cond;
	logic        end_match;
	logic        addr_change;
	logic [7:0]  first_read;
	logic [7:0]  wbyte;
	logic [7:0]  rbyte;
	logic        rd_ok;
	logic        wr_en;
	logic        wr_known;
	logic        wr_mask0_en;
	logic        wr_mask1_en;
	logic        ctl_write;
	logic        wr_eos_en;
	logic        wr_start;
	logic        rd_start;
	logic        b_done;
	logic        r_done;
	logic        end_event;
	logic        poll_fall;
	logic        remote_edge;
	logic        trig_event;
	logic        holdoff_set;
	logic        holdoff_release;

	// The register decode compares a full byte of address, so narrower buses cannot work.
	if (AW < 8 || AW > 32) begin : g_bad_aw
		$error("gis_interrupt_status address width out of range");
	end

	// Both channels are taken together in one cycle; awready and wready share a flop.
	assign wr_fire   = state.aw_ready && s_axi_awvalid && s_axi_wvalid;
	assign rd_fire   = state.ar_ready && s_axi_arvalid;
	assign wbyte     = s_axi_wdata[7:0];
	assign wr_en     = wr_fire && s_axi_wstrb[0];
	assign sw_reset  = ctl_write && wbyte[CTL_SWRST];
	assign rd_clear0 = rd_fire && (s_axi_araddr[7:0] == OFF_STATUS0);
	assign rd_clear1 = rd_fire && (s_axi_araddr[7:0] == OFF_STATUS1);

	// A channel is armed only while idle, so a new request cannot overtake the
	// response of the previous one.
	assign wr_start  = !state.aw_ready && !state.b_valid && s_axi_awvalid && s_axi_wvalid;
	assign rd_start  = !state.ar_ready && !state.r_valid && s_axi_arvalid;
	assign b_done    = state.b_valid && s_axi_bready;
	assign r_done    = state.r_valid && s_axi_rready;

	assign holdoff_release = sw_reset || (ctl_write && wbyte[CTL_RELEASE]);
	assign holdoff_set     = |(second_set & state.second_interrupt_mask & HOLDOFF_BITS);

	// Write decode is kept apart from the register update so that the response
	// code and the write enables always agree.
	always_comb begin
		wr_known    = 1'b1;
		wr_mask0_en = 1'b0;
		wr_mask1_en = 1'b0;
		ctl_write   = 1'b0;
		wr_eos_en   = 1'b0;
		case (s_axi_awaddr[7:0])
			OFF_MASK0: begin
				wr_mask0_en = wr_en;
			end
			OFF_MASK1: begin
				wr_mask1_en = wr_en;
			end
			OFF_CONTROL: begin
				ctl_write = wr_en;
			end
			OFF_EOS_BYTE: begin
				wr_eos_en = wr_en;
			end
			OFF_STATUS0, OFF_STATUS1, OFF_STATE: begin
				wr_known = 1'b1;
			end
			default: begin
				wr_known = 1'b0;
			end
		endcase
	end

	// End condition on an accepted byte while listener active.
	always_comb begin
		end_match = bus.eoi;
		if (state.eos_match_enable && bus.data_byte == state.end_of_string_byte_reg) begin
			end_match = 1'b1;
		end
		if (state.newline_end_enable && bus.data_byte == NEWLINE_CHAR) begin
			end_match = 1'b1;
		end
	end

	assign poll_cond = bus.service_request_talk && bus.serial_poll_active
		&& bus.affirmative_poll;

	// With pass-through enabled the device uses secondary addressing, so only
	// the unaddressing terms remain and becoming addressed is left to the
	// pass-through flag.
	always_comb begin
		addr_change = 1'b0;
		if (bus.accept_data) begin
			if (bus.my_talk_addr && !bus.talker_addressed
				&& !state.second_interrupt_mask[ST1_PASS]) begin
				addr_change = 1'b1;
			end
			if (bus.other_talk_addr && bus.talker_addressed) begin
				addr_change = 1'b1;
			end
			if (bus.my_listen_addr && !bus.listener_addressed
				&& !state.second_interrupt_mask[ST1_PASS]) begin
				addr_change = 1'b1;
			end
			if (bus.unlisten && bus.listener_addressed) begin
				addr_change = 1'b1;
			end
			if (state.dual_primary_enable && bus.alternate_primary) begin
				addr_change = 1'b0;
			end
		end
	end

	// The edge detectors reset to zero, so a remote state already high when
	// reset is released is reported as a change.
	assign end_event   = end_match && bus.listener_active && bus.accept_data;
	assign poll_fall   = state.poll_cond_q && !poll_cond;
	assign remote_edge = state.remote_q != bus.remote_state_bit;
	assign trig_event  = bus.trigger_cmd && bus.listener_addressed && bus.accept_data;

	always_comb begin
		first_set           = '0;
		first_set[ST0_END]  = end_event;
		first_set[ST0_SPAS] = poll_fall;
		first_set[ST0_RLC]  = remote_edge;
		first_set[ST0_MAC]  = addr_change;
	end

	always_comb begin
		second_set           = {1'b0, second_cond};
		second_set[ST1_TRIG] = trig_event;
	end

	gis_flag_reg #(
		.W (4)
	) u_first_flags (
		.clk      (clk),
		.rst      (rst),
		.set_ev   (first_set),
		.rd_clear (rd_clear0),
		.sw_clear (sw_reset),
		.flags    (first_flags)
	);

	gis_flag_reg #(
		.W (8)
	) u_second_flags (
		.clk      (clk),
		.rst      (rst),
		.set_ev   (second_set),
		.rd_clear (rd_clear1),
		.sw_clear (sw_reset),
		.flags    (second_flags)
	);

	// Masks act here, in holdoff_set and, via ST1_PASS, in addr_change; otherwise the flag registers record every event.
	assign sum0 = |(first_flags & state.first_interrupt_mask[3:0]);
	assign sum1 = |(second_flags & state.second_interrupt_mask);

	// Bits 5:4 carry no condition of this block and read as zero.
	assign first_read = {sum0, sum1, 2'b00, first_flags};

	// Read data mux; write-only registers answer zero.
	// It is sampled at the address handshake, the same edge that clears the
	// status register being read, so the host sees exactly the bits removed.
	always_comb begin
		rbyte = '0;
		rd_ok = 1'b1;
		case (s_axi_araddr[7:0])
			OFF_STATUS0: begin
				rbyte = first_read;
			end
			OFF_STATUS1: begin
				rbyte = second_flags;
			end
			OFF_MASK0, OFF_MASK1: begin
				rbyte = '0;
			end
			OFF_CONTROL: begin
				rbyte = '0;
				rbyte[CTL_EOS_EN]  = state.eos_match_enable;
				rbyte[CTL_NL_EN]   = state.newline_end_enable;
				rbyte[CTL_DUAL_EN] = state.dual_primary_enable;
			end
			OFF_EOS_BYTE: begin
				rbyte = state.end_of_string_byte_reg;
			end
			OFF_STATE: begin
				rbyte    = '0;
				rbyte[7] = bus.remote_state_bit;
				rbyte[0] = state.holdoff;
			end
			default: begin
				rd_ok = 1'b0;
			end
		endcase
	end

	always_comb begin
		next_state             = state;
		next_state.poll_cond_q = poll_cond;
		next_state.remote_q    = bus.remote_state_bit;

		// Write address and data channels.
		if (wr_fire) begin
			next_state.aw_ready = 1'b0;
			next_state.b_valid  = 1'b1;
			next_state.b_resp   = wr_known ? RESP_OKAY : RESP_SLVERR;
			if (wr_mask0_en) begin
				next_state.first_interrupt_mask = wbyte;
			end
			if (wr_mask1_en) begin
				next_state.second_interrupt_mask = wbyte;
			end
			if (ctl_write) begin
				next_state.eos_match_enable    = wbyte[CTL_EOS_EN];
				next_state.newline_end_enable  = wbyte[CTL_NL_EN];
				next_state.dual_primary_enable = wbyte[CTL_DUAL_EN];
			end
			if (wr_eos_en) begin
				next_state.end_of_string_byte_reg = wbyte;
			end
		end else if (wr_start) begin
			next_state.aw_ready = 1'b1;
		end
		if (b_done) begin
			next_state.b_valid = 1'b0;
		end

		// Read channels; the clear-on-read happens at the address handshake.
		if (rd_fire) begin
			next_state.ar_ready = 1'b0;
			next_state.r_valid  = 1'b1;
			next_state.r_data   = {24'h000000, rbyte};
			next_state.r_resp   = rd_ok ? RESP_OKAY : RESP_SLVERR;
		end else if (rd_start) begin
			next_state.ar_ready = 1'b1;
		end
		if (r_done) begin
			next_state.r_valid = 1'b0;
		end

		// Handshake holdoff: a new enabled command event wins over a release.
		if (holdoff_release) begin
			next_state.holdoff = 1'b0;
		end
		if (holdoff_set) begin
			next_state.holdoff = 1'b1;
		end

		// The pin is registered after the summaries; it lags the flags by one
		// cycle but cannot glitch while the flags update.
		next_state.irq = sum0 || sum1;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state                        <= '0;
			state.first_interrupt_mask   <= MASK_RESET;
			state.second_interrupt_mask  <= MASK_RESET;
			state.end_of_string_byte_reg <= EOS_RESET;
		end else begin
			state <= next_state;
		end
	end

	assign s_axi_awready = state.aw_ready;
	assign s_axi_wready  = state.aw_ready;
	assign s_axi_bvalid  = state.b_valid;
	assign s_axi_bresp   = state.b_resp;
	assign s_axi_arready = state.ar_ready;
	assign s_axi_rvalid  = state.r_valid;
	assign s_axi_rresp   = state.r_resp;
	assign s_axi_rdata   = state.r_data;
	assign irq           = state.irq;
	assign dac_holdoff   = state.holdoff;

endmodule : gis_interrupt_status

/* File: gis_interrupt_status_bench.sv */
// Self-checking bench for the bus interrupt status logic.
module gis_interrupt_status_bench
	import gis_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	localparam gis_bus_type EOI_EV = '{listener_active: 1'b1, accept_data: 1'b1, eoi: 1'b1,
		default: '0};
	logic              clk = 1'b0;
	logic              rst = 1'b1;
	logic [ADDR_W-1:0] s_axi_awaddr = '0;
	logic              s_axi_awvalid = 1'b0;
	logic [DATA_W-1:0] s_axi_wdata = '0;
	logic [3:0]        s_axi_wstrb = 4'hF;
	logic              s_axi_wvalid = 1'b0;
	logic              s_axi_bready = 1'b0;
	logic [ADDR_W-1:0] s_axi_araddr = '0;
	logic              s_axi_arvalid = 1'b0;
	logic              s_axi_rready = 1'b0;
	logic              s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]        s_axi_bresp, s_axi_rresp;
	logic [DATA_W-1:0] s_axi_rdata;
	logic              irq, dac_holdoff;
	gis_bus_type       bus;
	logic [6:0]        second_cond;
	int                error_cnt = 0;
	int                tests_run = 0;
	always #50 clk = ~clk;
	gis_interrupt_status i_gis_interrupt_status (.clk, .rst, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .bus, .second_cond, .irq,
		.dac_holdoff);
	gis_bus_model i_gis_bus_model (.clk, .bus, .second_cond);
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask : check
	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er = RESP_OKAY);
		bit aw_ok;
		bit w_ok;
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		do begin
			@(posedge clk);
			if (s_axi_awready === 1'b1) begin
				aw_ok = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (s_axi_wready === 1'b1) begin
				w_ok = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end while (!(aw_ok && w_ok));
		while (s_axi_bvalid !== 1'b1) @(posedge clk);
		s_axi_bready <= 1'b0;
		check(s_axi_bresp, er);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er = RESP_OKAY);
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge clk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do @(posedge clk); while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
		check(s_axi_rdata, exp);
		check(s_axi_rresp, er);
	endtask : rd
	task automatic ev(input gis_bus_type v);
		i_gis_bus_model.pulse(v);
		repeat (2) @(posedge clk);
	endtask : ev
	task automatic t_reset();
		wr(8'h1C, 8'hFF, RESP_SLVERR);
		rd(8'h1C, 32'h0, RESP_SLVERR);
		wr(OFF_MASK1, 8'hFF);
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		i_gis_bus_model.cond(7'h01);
		repeat (3) @(posedge clk);
		check(irq, 1'b0);
		rd(OFF_STATUS1, 32'h01);
	endtask : t_reset
	task automatic t_end();
		logic [7:0] db [5] = '{8'h55, 8'h0A, 8'h33, 8'h33, 8'h0A};
		logic [4:0] eo = 5'b10100;
		logic [4:0] la = 5'b01111;
		logic [4:0] ex = 5'b00111;
		wr(OFF_EOS_BYTE, 8'h55);
		wr(OFF_CONTROL, 8'h0C);
		rd(OFF_CONTROL, 32'h0C);
		s_axi_wstrb <= 4'h0;
		wr(OFF_EOS_BYTE, 8'hAA);
		s_axi_wstrb <= 4'hF;
		rd(OFF_EOS_BYTE, 32'h55);
		for (int i = 0; i < 5; i++) begin
			ev('{listener_active: la[i], accept_data: 1'b1, eoi: eo[i], data_byte: db[i], default: '0});
			rd(OFF_STATUS0, {28'h0, ex[i], 3'h0});
		end
		ev(EOI_EV);
		wr(OFF_CONTROL, 8'h01);
		rd(OFF_STATUS0, 32'h0);
		wr(OFF_MASK0, 8'h08);
		ev(EOI_EV);
		check(irq, 1'b1);
		rd(OFF_STATUS0, 32'h88);
		repeat (2) @(posedge clk);
		check(irq, 1'b0);
		wr(OFF_MASK0, 8'h00);
	endtask : t_end
	task automatic t_poll_rlc();
		i_gis_bus_model.set_base('{service_request_talk: 1'b1, serial_poll_active: 1'b1,
			affirmative_poll: 1'b1, remote_state_bit: 1'b1, default: '0});
		rd(OFF_STATE, 32'h80);
		rd(OFF_STATUS0, 32'h02);
		i_gis_bus_model.set_base('{remote_state_bit: 1'b1, default: '0});
		rd(OFF_STATUS0, 32'h04);
		i_gis_bus_model.set_base('0);
		rd(OFF_STATUS0, 32'h02);
	endtask : t_poll_rlc
	task automatic t_mac();
		ev('{accept_data: 1'b1, my_talk_addr: 1'b1, default: '0});
		rd(OFF_STATUS0, 32'h01);
		ev('{accept_data: 1'b1, other_talk_addr: 1'b1, default: '0});
		rd(OFF_STATUS0, 32'h00);
		wr(OFF_MASK1, 8'h10);
		ev('{accept_data: 1'b1, my_listen_addr: 1'b1, default: '0});
		rd(OFF_STATUS0, 32'h00);
		ev('{accept_data: 1'b1, unlisten: 1'b1, listener_addressed: 1'b1, default: '0});
		rd(OFF_STATUS0, 32'h01);
		wr(OFF_MASK1, 8'h00);
		wr(OFF_CONTROL, 8'h10);
		ev('{accept_data: 1'b1, my_talk_addr: 1'b1, alternate_primary: 1'b1, default: '0});
		rd(OFF_STATUS0, 32'h00);
		wr(OFF_CONTROL, 8'h00);
	endtask : t_mac
	task automatic t_second();
		wr(OFF_MASK1, 8'h7F);
		for (int i = 0; i < 7; i++) begin
			i_gis_bus_model.cond(7'(1 << i));
			repeat (3) @(posedge clk);
			check(dac_holdoff, HOLDOFF_BITS[i]);
			check(irq, 1'b1);
			rd(OFF_STATUS1, 32'(1 << i));
			rd(OFF_STATUS1, 32'h0);
			check(irq, 1'b0);
			wr(OFF_CONTROL, 8'h02);
		end
		wr(OFF_MASK1, 8'h80);
		ev('{accept_data: 1'b1, trigger_cmd: 1'b1, default: '0});
		rd(OFF_STATUS1, 32'h0);
		ev('{accept_data: 1'b1, trigger_cmd: 1'b1, listener_addressed: 1'b1, default: '0});
		check(dac_holdoff, 1'b1);
		rd(OFF_STATUS0, 32'h40);
		rd(OFF_STATUS1, 32'h80);
		rd(OFF_STATE, 32'h01);
		wr(OFF_CONTROL, 8'h02);
		rd(OFF_STATE, 32'h0);
		wr(OFF_MASK1, 8'h00);
	endtask : t_second
	// The event is placed on the read handshake edge, two edges after the read starts.
	task automatic t_defer();
		fork
			rd(OFF_STATUS1, 32'h0);
			begin
				@(posedge clk);
				i_gis_bus_model.cond(7'h02);
			end
		join
		rd(OFF_STATUS1, 32'h02);
	endtask : t_defer
	task automatic stop_test();
		$display("checks %0d errors %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : stop_test
	initial begin
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_end();
		t_poll_rlc();
		t_mac();
		t_second();
		t_defer();
		stop_test();
	end
	initial begin
		#(100 * 20000);
		error_cnt++;
		stop_test();
	end
endmodule : gis_interrupt_status_bench

/* File: gis_interrupt_status_properties.sv */
// Checker of handshake, interrupt and holdoff timing at the block's ports.
module gis_interrupt_status_properties
	import gis_pkg::*;
(
	input  wire logic              clk,
	input  wire logic              rst,
	input  wire logic              s_axi_awready,
	input  wire logic              s_axi_wready,
	input  wire logic [1:0]        s_axi_bresp,
	input  wire logic              s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic              s_axi_arready,
	input  wire logic [DATA_W-1:0] s_axi_rdata,
	input  wire logic              s_axi_rvalid,
	input  wire logic              s_axi_rready,
	input  wire gis_bus_type       bus,
	input  wire logic [6:0]        second_cond,
	input  wire logic              irq,
	input  wire logic              dac_holdoff
);
	timeunit 1ns;
	timeprecision 1ns;
	gis_bus_type bus_q;
	logic        ev;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			bus_q <= '0;
		end else begin
			bus_q <= bus;
		end
	end
	// Any bus change or raised second_cond bit counts as a cause, a loose superset that keeps the check safe.
	assign ev = (bus != bus_q) || (|second_cond);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	sequence s_aw_take;
		s_axi_awready && s_axi_wready;
	endsequence
	sequence s_b_wait;
		s_axi_bvalid && !s_axi_bready;
	endsequence
	a_aw_pulse: assert property (s_axi_awready |=> !s_axi_awready)
		else $error("awready held too long");
	a_b_follow: assert property (s_aw_take |=> s_axi_bvalid)
		else $error("write response late");
	a_b_hold: assert property (s_b_wait |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	a_irq_rise: assert property ($rose(irq) |-> $past(ev, 2) || $past(ev, 3) || $past(ev, 4)
		|| $past(s_axi_wready) || $past(s_axi_wready, 2)) else $error("irq rose without cause");
	a_irq_fall: assert property ($fell(irq) |-> $past(s_axi_arready, 2) || $past(s_axi_wready)
		|| $past(s_axi_wready, 2)) else $error("irq fell without access");
	a_hold_rise: assert property ($rose(dac_holdoff) |-> $past(bus.trigger_cmd)
		|| $past(|second_cond[5:2])) else $error("holdoff without command event");
	a_r_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
		else $error("read data upper bits set");
endmodule : gis_interrupt_status_properties

bind gis_interrupt_status gis_interrupt_status_properties i_gis_interrupt_status_properties (
	.clk, .rst, .s_axi_awready, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
	.s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .bus, .second_cond, .irq,
	.dac_holdoff);

/* File: gis_pkg.sv */
// Package of constants and carrier types for the bus interrupt status logic.
package gis_pkg;

	localparam int          DATA_W        = 32;
	localparam int          ADDR_W        = 8;

	localparam logic [7:0]  OFF_STATUS0   = 8'h00;
	localparam logic [7:0]  OFF_MASK0     = 8'h04;
	localparam logic [7:0]  OFF_STATUS1   = 8'h08;
	localparam logic [7:0]  OFF_MASK1     = 8'h0C;
	localparam logic [7:0]  OFF_CONTROL   = 8'h10;
	localparam logic [7:0]  OFF_EOS_BYTE  = 8'h14;
	localparam logic [7:0]  OFF_STATE     = 8'h18;

	localparam int          CTL_SWRST     = 0;
	localparam int          CTL_RELEASE   = 1;
	localparam int          CTL_EOS_EN    = 2;
	localparam int          CTL_NL_EN     = 3;
	localparam int          CTL_DUAL_EN   = 4;

	localparam int          ST0_MAC       = 0;
	localparam int          ST0_RLC       = 1;
	localparam int          ST0_SPAS      = 2;
	localparam int          ST0_END       = 3;

	localparam int          ST1_TRIG      = 7;
	localparam int          ST1_PASS      = 4;
	localparam logic [7:0]  HOLDOFF_BITS  = 8'hBC;

	localparam logic [7:0]  NEWLINE_CHAR  = 8'h0A;
	localparam logic [7:0]  MASK_RESET    = 8'h00;
	localparam logic [7:0]  EOS_RESET     = 8'h00;
	localparam logic [1:0]  RESP_OKAY     = 2'h0;
	localparam logic [1:0]  RESP_SLVERR   = 2'h2;

	typedef struct packed {
		logic        listener_active;
		logic        accept_data;
		logic        eoi;
		logic [7:0]  data_byte;
		logic        service_request_talk;
		logic        serial_poll_active;
		logic        affirmative_poll;
		logic        remote_state_bit;
		logic        my_talk_addr;
		logic        other_talk_addr;
		logic        my_listen_addr;
		logic        unlisten;
		logic        talker_addressed;
		logic        listener_addressed;
		logic        alternate_primary;
		logic        trigger_cmd;
	} gis_bus_type;

	typedef struct packed {
		logic        aw_ready;
		logic        b_valid;
		logic [1:0]  b_resp;
		logic        ar_ready;
		logic        r_valid;
		logic [1:0]  r_resp;
		logic [31:0] r_data;
		logic [7:0]  first_interrupt_mask;
		logic [7:0]  second_interrupt_mask;
		logic        eos_match_enable;
		logic        newline_end_enable;
		logic        dual_primary_enable;
		logic [7:0]  end_of_string_byte_reg;
		logic        holdoff;
		logic        poll_cond_q;
		logic        remote_q;
		logic        irq;
	} gis_top_type;

endpackage : gis_pkg
